// ### design/pfm_pkg.sv
// constants shared by the pin function multiplexer
package pfm_pkg;
   localparam int MUX_REG_W = 8;
   localparam int MUX_REG_CNT = 3;
   localparam int MUX_BITS = MUX_REG_W * MUX_REG_CNT;
   localparam int MUX_IDX_W = 2;
   localparam int SYNC_STAGES = 2;
   localparam int GEN_OUT_N = 12;
   localparam int GEN_IN_N = 8;
   localparam int GP_N = 22;
   localparam logic [MUX_REG_W-1:0] MUX_REG_RST = 8'h00;
   // multiplexing bit positions
   localparam int MB_IRQ = 0;
   localparam int MB_KBD_PORT = 1;
   localparam int MB_CSER = 3;
   localparam int MB_PWM = 4;
   localparam int MB_FDD2 = 5;
   localparam int MB_A20 = 6;
   localparam int MB_IRSER = 7;
   localparam int MB_MEDIA = 8;
   localparam int MB_KSCAN = 9;
   localparam int MB_DRQ2 = 10;
   localparam int MB_DRQ3 = 11;
   localparam int MB_UART2 = 12;
   localparam int MB_SEL6_LO = 13;
   localparam int MB_SEL10_LO = 15;
   localparam int MB_DACK2 = 17;
   localparam int CONTROLLER_INTERRUPT_1_TRIG_BIT = 3;
   typedef logic [1:0] pfm_sel_t;
   // selector encodings, cleared field always means the default function
   localparam pfm_sel_t SEL_DEFAULT = 2'h0;
   localparam pfm_sel_t SEL6_IRMODE = 2'h1;
   localparam pfm_sel_t SEL6_FRX = 2'h2;
   localparam pfm_sel_t SEL10_RTS = 2'h1;
   localparam pfm_sel_t SEL10_IRMODE = 2'h2;
   localparam pfm_sel_t SEL10_FRX = 2'h3;
   localparam pfm_sel_t GENERIC_OUTPUT_8_DRQ = 2'h2;
   localparam pfm_sel_t GENERIC_OUTPUT_8_RST = 2'h3;
   localparam pfm_sel_t KEY_SCAN_OUT_12_ALT = 2'h3;
   localparam pfm_sel_t KBD_PS = 2'h2;
   localparam pfm_sel_t KBD_CSER = 2'h3;
endpackage

// ### design/pfm_sync.sv
// two-flop synchronisers for pin inputs
`timescale 1ns/100ps
`default_nettype none
module pfm_sync
   import pfm_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk) begin
            if (rst) begin
               meta_reg[i] <= 1'b0;
               sync_reg[i] <= 1'b0;
            end else begin
               meta_reg[i] <= async_in[i];
               sync_reg[i] <= meta_reg[i];
            end
         end
      end
   endgenerate
   assign sync_out = sync_reg;
endmodule // pfm_sync
`default_nettype wire

// ### design/pfm_mux_regs.sv
// three multiplexing registers, controller read and write
`timescale 1ns/100ps
`default_nettype none
module pfm_mux_regs
   import pfm_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [MUX_IDX_W-1:0] wr_idx,
   input wire logic [MUX_REG_W-1:0] wr_data,
   input wire logic [MUX_IDX_W-1:0] rd_idx,
   output logic [MUX_REG_W-1:0] rd_data,
   output logic [MUX_BITS-1:0] mux_bits
);
   logic [MUX_REG_W-1:0] mux_reg [MUX_REG_CNT];
   logic [MUX_REG_W-1:0] mux_next [MUX_REG_CNT];
   logic [MUX_REG_W-1:0] rd_reg;
   logic [MUX_REG_W-1:0] rd_next;

   always_comb begin
      for (int r = 0; r < MUX_REG_CNT; r++) begin
         mux_next[r] = mux_reg[r];
         if (wr_en && (int'(wr_idx) == r)) begin
            mux_next[r] = wr_data;
         end
      end
      // unused index reads zero
      rd_next = 8'h00;
      if (int'(rd_idx) < MUX_REG_CNT) begin
         rd_next = mux_reg[rd_idx];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int r = 0; r < MUX_REG_CNT; r++) begin
            mux_reg[r] <= MUX_REG_RST;
         end
         rd_reg <= 8'h00;
      end else begin
         mux_reg <= mux_next;
         rd_reg <= rd_next;
      end
   end

   genvar g;
   generate
      for (g = 0; g < MUX_REG_CNT; g++) begin : g_flat
         assign mux_bits[g*MUX_REG_W +: MUX_REG_W] = mux_reg[g];
      end
   endgenerate
   assign rd_data = rd_reg;
endmodule // pfm_mux_regs
`default_nettype wire

// ### design/pfm_pin_mux.sv
// pin function multiplexer top
// What this block does
// R1: mux bit 0 puts isa interrupts 6,8,7,12,1 on outputs 0-4, smi on 7.
// R2: mux bit 0 turns serialized interrupt pin into direct uart1 interrupt 3.
// R3: mux bit 5 gives outputs 5,6 second drive select/motor, push-pull or open-drain.
// R4: output 8 carries dma request 2 or cpu reset, by bits 10 and 6.
// R5: mux bit 11 puts dma request 3 on output 9, ack 3 from gp 19.
// R6: mux bit 4 puts pulse modulators 0 and 1 on outputs 10, 11.
// R7: generic inputs 0-7 double as wake events, each gated by wake mask.
// R8: gp 0-2 are wake inputs, gp 3 triggers interrupt 1 via mask bit 3.
// R9: mux bit 9 makes gp 4,5 open-drain key scan outputs 14,15.
// R10: field 14:13 makes gp 6 infrared mode output or fast infrared receive.
// R11: mux bit 7 makes gp 8 infrared receive, gp 9 infrared transmit.
// R12: field 16:15 makes gp 10 uart2 rts, infrared mode or fast receive.
// R13: mux bit 12 makes gp 11-15 the second uart modem lines.
// R14: mux bit 8 makes gp 16 the media id bit 1 input.
// R15: mux bit 6 puts the a20 gate output on gp 17.
// R16: mux bit 17 makes gp 18 the dma ack 2 input.
// R17: gp 20,21 carry keyboard port pair or controller serial, by bits 1 and 3.
// R18: key scan 12,13 carry output 8 and gp 18 open-drain, by bits 17, 6.
// R19: supply not good tri-states infrared mode, transmit, rts and dtr pins.
// R20: all mux bits live in three controller read/write registers.
// R21: a cleared mux bit or field selects the pin's default function.
// R22: selector encodings and combined-bit codes are parameters.
`timescale 1ns/100ps
`default_nettype none
module pfm_pin_mux
   import pfm_pkg::*;
#( // R22
   parameter pfm_sel_t P_SEL6_IRMODE = SEL6_IRMODE,
   parameter pfm_sel_t P_SEL6_FRX = SEL6_FRX,
   parameter pfm_sel_t P_SEL10_RTS = SEL10_RTS,
   parameter pfm_sel_t P_SEL10_IRMODE = SEL10_IRMODE,
   parameter pfm_sel_t P_SEL10_FRX = SEL10_FRX,
   parameter pfm_sel_t P_GENERIC_OUTPUT_8_DRQ = GENERIC_OUTPUT_8_DRQ,
   parameter pfm_sel_t P_GENERIC_OUTPUT_8_RST = GENERIC_OUTPUT_8_RST,
   parameter pfm_sel_t P_KEY_SCAN_OUT_12_ALT = KEY_SCAN_OUT_12_ALT,
   parameter pfm_sel_t P_KBD_PS = KBD_PS,
   parameter pfm_sel_t P_KBD_CSER = KBD_CSER
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic mux_wr_en,
   input wire logic [MUX_IDX_W-1:0] mux_wr_idx,
   input wire logic [MUX_REG_W-1:0] mux_wr_data,
   input wire logic [MUX_IDX_W-1:0] mux_rd_idx,
   output logic [MUX_REG_W-1:0] mux_rd_data,
   input wire logic main_supply_good,
   input wire logic [GEN_OUT_N-1:0] gen_out_dflt,
   input wire logic isa_int6,
   input wire logic isa_int8_low,
   input wire logic isa_int7,
   input wire logic isa_int12,
   input wire logic isa_controller_interrupt_1,
   input wire logic sys_mgmt_interrupt_low,
   input wire logic serialized_interrupt,
   input wire logic serialized_interrupt_oe,
   input wire logic isa_int3,
   input wire logic floppy_drive_select_1_low,
   input wire logic floppy_motor_1_low,
   input wire logic floppy_open_drain,
   input wire logic dma_req_2,
   input wire logic cpu_reset,
   input wire logic dma_req_3,
   input wire logic pulse_mod_out_0,
   input wire logic pulse_mod_out_1,
   input wire logic [GP_N-1:0] gp_dflt_out,
   input wire logic [GP_N-1:0] gp_dflt_oe,
   input wire logic [3:0] key_scan_dflt,
   input wire logic infrared_mode_select,
   input wire logic infrared_serial_transmit,
   input wire logic uart2_request_to_send_low,
   input wire logic uart2_terminal_ready_low,
   input wire logic addr_line_20_gate,
   input wire logic kbd_port_clock_drive_low,
   input wire logic kbd_port_data_drive_low,
   input wire logic controller_serial_transmit,
   input wire logic [GEN_IN_N-1:0] wake_mask,
   input wire logic [MUX_REG_W-1:0] controller_interrupt_1_mask,
   input wire logic [GEN_IN_N-1:0] gen_in_pin,
   input wire logic [GP_N-1:0] gp_pin_in,
   output logic [GEN_OUT_N-1:0] gen_out_pin,
   output logic [GEN_OUT_N-1:0] gen_out_oe,
   output logic serialized_interrupt_pin_out,
   output logic serialized_interrupt_pin_oe,
   output logic [GP_N-1:0] gp_pin_out,
   output logic [GP_N-1:0] gp_pin_oe,
   output logic [1:0] kscan_pin_out,
   output logic [1:0] kscan_pin_oe,
   output logic [GEN_IN_N-1:0] gen_in_value,
   output logic [GEN_IN_N-1:0] wake_event,
   output logic [GP_N-1:0] gp_in_value,
   output logic [2:0] gp_wake,
   output logic controller_interrupt_1,
   output logic infrared_serial_receive,
   output logic fast_infrared_receive,
   output logic uart2_clear_to_send_low,
   output logic uart2_set_ready_low,
   output logic uart2_carrier_detect_low,
   output logic uart2_ring_indicator_low,
   output logic media_id_bit_1,
   output logic dma_ack_2_low,
   output logic dma_ack_3_low,
   output logic kbd_port_clock,
   output logic kbd_port_data,
   output logic controller_serial_receive
);
   ////////////////////////////////////////////////////////////////////////////
   logic [MUX_BITS-1:0] m;
   logic [GEN_IN_N-1:0] gi_s;
   logic [GP_N-1:0] gp_s;
   logic pg_s;

   pfm_mux_regs u_regs ( // R20
      .clk(clk), .rst(rst), .wr_en(mux_wr_en), .wr_idx(mux_wr_idx),
      .wr_data(mux_wr_data), .rd_idx(mux_rd_idx), .rd_data(mux_rd_data),
      .mux_bits(m)
   );
   pfm_sync #(.WIDTH(GEN_IN_N + GP_N + 1)) u_sync (
      .clk(clk), .rst(rst),
      .async_in({main_supply_good, gp_pin_in, gen_in_pin}),
      .sync_out({pg_s, gp_s, gi_s})
   );

   pfm_sel_t sel6, sel10, generic_output_8_code, key_scan_out_12_code, kbd_code;
   assign sel6 = m[MB_SEL6_LO +: 2];
   assign sel10 = m[MB_SEL10_LO +: 2];
   assign generic_output_8_code = {m[MB_DRQ2], m[MB_A20]};
   assign key_scan_out_12_code = {m[MB_DACK2], m[MB_A20]};
   assign kbd_code = {m[MB_KBD_PORT], m[MB_CSER]};

   ////////////////////////////////////////////////////////////////////////////
   // output side
   logic [GEN_OUT_N-1:0] go_reg, go_next, goe_reg, goe_next;
   logic [GP_N-1:0] gpo_reg, gpo_next, gpoe_reg, gpoe_next;
   logic sq_reg, sq_next, sqoe_reg, sqoe_next;
   logic [1:0] ko_reg, ko_next, koe_reg, koe_next;
   logic generic_output_8_alt;

   always_comb begin
      // R21
      go_next = gen_out_dflt;
      goe_next = '1;
      gpo_next = gp_dflt_out;
      gpoe_next = gp_dflt_oe;
      sq_next = serialized_interrupt;
      sqoe_next = serialized_interrupt_oe;
      generic_output_8_alt = 1'b0;
      if (m[MB_IRQ]) begin
         go_next[4:0] = {isa_controller_interrupt_1, isa_int12, isa_int7, isa_int8_low, isa_int6}; // R1
         go_next[7] = sys_mgmt_interrupt_low; // R1
         sq_next = isa_int3; // R2
         sqoe_next = 1'b1; // R2
      end
      if (m[MB_FDD2]) begin
         go_next[6:5] = {floppy_motor_1_low, floppy_drive_select_1_low}; // R3
         // open-drain mode drives only the low level
         if (floppy_open_drain) begin
            go_next[6:5] = 2'h0; // R3
            goe_next[6:5] = ~{floppy_motor_1_low, floppy_drive_select_1_low}; // R3
         end
      end
      if (generic_output_8_code == P_GENERIC_OUTPUT_8_DRQ) begin
         go_next[8] = dma_req_2; // R4
         generic_output_8_alt = 1'b1;
      end else if (generic_output_8_code == P_GENERIC_OUTPUT_8_RST) begin
         go_next[8] = cpu_reset; // R4
         generic_output_8_alt = 1'b1;
      end
      if (m[MB_DRQ3]) begin
         go_next[9] = dma_req_3; // R5
         gpoe_next[19] = 1'b0; // R5
      end
      if (m[MB_PWM]) begin
         go_next[11:10] = {pulse_mod_out_1, pulse_mod_out_0}; // R6
      end
      // wake and trigger pins gp 0-3 are always inputs, overriding the gpio default output enable
      gpoe_next[3:0] = 4'h0; // R8
      if (m[MB_KSCAN]) begin
         gpo_next[5:4] = 2'h0; // R9
         gpoe_next[5:4] = ~key_scan_dflt[3:2]; // R9
      end
      case (sel6) // R10
         P_SEL6_IRMODE: begin
            gpo_next[6] = infrared_mode_select;
            gpoe_next[6] = pg_s; // R19
         end
         P_SEL6_FRX: gpoe_next[6] = 1'b0;
         default: ;
      endcase
      if (m[MB_IRSER]) begin
         gpoe_next[8] = 1'b0; // R11
         gpo_next[9] = infrared_serial_transmit; // R11
         gpoe_next[9] = pg_s; // R19
      end
      case (sel10) // R12
         P_SEL10_RTS: begin
            gpo_next[10] = uart2_request_to_send_low;
            gpoe_next[10] = pg_s; // R19
         end
         P_SEL10_IRMODE: begin
            gpo_next[10] = infrared_mode_select;
            gpoe_next[10] = pg_s; // R19
         end
         P_SEL10_FRX: gpoe_next[10] = 1'b0;
         default: ;
      endcase
      if (m[MB_UART2]) begin
         gpoe_next[11] = 1'b0; // R13
         gpoe_next[15:13] = 3'h0; // R13
         gpo_next[12] = uart2_terminal_ready_low; // R13
         gpoe_next[12] = pg_s; // R19
      end
      if (m[MB_MEDIA]) begin
         gpoe_next[16] = 1'b0; // R14
      end
      if (m[MB_A20]) begin
         gpo_next[17] = addr_line_20_gate; // R15
         gpoe_next[17] = 1'b1; // R15
      end
      if (m[MB_DACK2]) begin
         gpoe_next[18] = 1'b0; // R16
      end
      // both lines of the pair are open-drain for the keyboard port; for controller serial gp 21 is open-drain transmit, gp 20 an input
      if (kbd_code == P_KBD_PS) begin
         gpo_next[21:20] = 2'h0; // R17
         gpoe_next[21:20] = {kbd_port_data_drive_low, kbd_port_clock_drive_low}; // R17
      end else if (kbd_code == P_KBD_CSER) begin
         gpo_next[21:20] = 2'h0; // R17
         gpoe_next[21:20] = {~controller_serial_transmit, 1'b0}; // R17
      end
      // key scan 12/13 are open-drain: oe asserts to pull low
      ko_next = 2'h0;
      koe_next[0] = (key_scan_out_12_code == P_KEY_SCAN_OUT_12_ALT) ? ~go_next[8] : ~key_scan_dflt[0]; // R18
      koe_next[1] = m[MB_DACK2] ? ~gp_dflt_out[18] : ~key_scan_dflt[1]; // R18
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         {go_reg, goe_reg, gpo_reg, gpoe_reg} <= '0;
         {sq_reg, sqoe_reg, ko_reg, koe_reg} <= '0;
      end else begin
         {go_reg, goe_reg, gpo_reg, gpoe_reg} <= {go_next, goe_next, gpo_next, gpoe_next};
         {sq_reg, sqoe_reg, ko_reg, koe_reg} <= {sq_next, sqoe_next, ko_next, koe_next};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // input side: inactive alternates idle high (deasserted for low-true lines), except fast infrared receive and media id bit 1, which idle low
   logic [GEN_IN_N-1:0] wk_next, wk_reg;
   logic [2:0] gw_next, gw_reg;
   logic [12:0] ai_next, ai_reg;

   always_comb begin
      wk_next = gi_s & wake_mask; // R7
      gw_next = gp_s[2:0]; // R8
      ai_next[0] = gp_s[3] & controller_interrupt_1_mask[CONTROLLER_INTERRUPT_1_TRIG_BIT]; // R8
      ai_next[1] = m[MB_IRSER] ? gp_s[8] : 1'b1; // R11
      // gp 6 wins if both pins are set to fast receive
      ai_next[2] = (sel6 == P_SEL6_FRX) ? gp_s[6] :
         ((sel10 == P_SEL10_FRX) & gp_s[10]); // R10 R12
      ai_next[6:3] = m[MB_UART2] ? {gp_s[15], gp_s[14], gp_s[13], gp_s[11]} : 4'hF; // R13
      ai_next[7] = m[MB_MEDIA] & gp_s[16]; // R14
      ai_next[8] = m[MB_DACK2] ? gp_s[18] : 1'b1; // R16
      ai_next[9] = m[MB_DRQ3] ? gp_s[19] : 1'b1; // R5
      ai_next[11:10] = (kbd_code == P_KBD_PS) ? gp_s[21:20] : 2'h3; // R17
      ai_next[12] = (kbd_code == P_KBD_CSER) ? gp_s[20] : 1'b1; // R17
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         {wk_reg, gw_reg, ai_reg} <= '0;
      end else begin
         {wk_reg, gw_reg, ai_reg} <= {wk_next, gw_next, ai_next};
      end
   end

   assign {gen_out_pin, gen_out_oe} = {go_reg, goe_reg};
   assign {gp_pin_out, gp_pin_oe} = {gpo_reg, gpoe_reg};
   assign {serialized_interrupt_pin_out, serialized_interrupt_pin_oe} = {sq_reg, sqoe_reg};
   assign {kscan_pin_out, kscan_pin_oe} = {ko_reg, koe_reg};
   assign {gen_in_value, gp_in_value} = {gi_s, gp_s};
   assign {wake_event, gp_wake} = {wk_reg, gw_reg};
   assign {controller_serial_receive, kbd_port_data, kbd_port_clock, dma_ack_3_low,
      dma_ack_2_low, media_id_bit_1, uart2_ring_indicator_low, uart2_carrier_detect_low,
      uart2_set_ready_low, uart2_clear_to_send_low, fast_infrared_receive,
      infrared_serial_receive, controller_interrupt_1} = ai_reg;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_wr_reg0_bit0;
      mux_wr_en && mux_wr_idx == 2'h0 && mux_wr_data[MB_IRQ];
   endsequence
   property p_irq_route;
      s_wr_reg0_bit0 ##1 m[MB_IRQ] ##1 1'b1 |-> serialized_interrupt_pin_out == $past(isa_int3);
   endproperty
   a_irq_route: assert property (p_irq_route) else $error("serialized_interrupt not uart1 irq"); // R2
   property p_irq_out;
      $past(m[MB_IRQ]) |-> gen_out_pin[1] == $past(isa_int8_low) && gen_out_pin[7] ==
         $past(sys_mgmt_interrupt_low);
   endproperty
   a_irq_out: assert property (p_irq_out) else $error("irq outputs wrong"); // R1
   property p_default;
      !$past(rst) && $past(m == '0) |-> gen_out_pin == $past(gen_out_dflt);
   endproperty
   a_default: assert property (p_default) else $error("default not kept"); // R21
   property p_pwm;
      $past(m[MB_PWM]) |-> gen_out_pin[11] == $past(pulse_mod_out_1);
   endproperty
   a_pwm: assert property (p_pwm) else $error("pwm1 not routed"); // R6
   property p_wake;
      $past(gi_s[0] && !wake_mask[0]) |-> !wake_event[0];
   endproperty
   a_wake: assert property (p_wake) else $error("masked wake passed"); // R7
   property p_pg_tri;
      $past(!pg_s && m[MB_IRSER]) |-> !gp_pin_oe[9];
   endproperty
   a_pg_tri: assert property (p_pg_tri) else $error("tx driven without power"); // R19
   property p_dtr_tri;
      $past(!pg_s && m[MB_UART2]) |-> !gp_pin_oe[12];
   endproperty
   a_dtr_tri: assert property (p_dtr_tri) else $error("dtr driven without power"); // R19
   property p_a20;
      $past(m[MB_A20]) |-> gp_pin_oe[17] && gp_pin_out[17] == $past(addr_line_20_gate);
   endproperty
   a_a20: assert property (p_a20) else $error("a20 not on gp17"); // R15
   property p_kscan;
      $past(m[MB_KSCAN]) |-> gp_pin_out[4] == 1'b0 && gp_pin_oe[4] == !$past(key_scan_dflt[2]);
   endproperty
   a_kscan: assert property (p_kscan) else $error("key scan 14 wrong"); // R9
   property p_rdback;
      mux_wr_en && mux_wr_idx == 2'h1 ##1 mux_rd_idx == 2'h1 && !mux_wr_en |=>
         mux_rd_data == $past(mux_wr_data, 2);
   endproperty
   a_rdback: assert property (p_rdback) else $error("mux register readback"); // R20
endmodule // pfm_pin_mux
`default_nettype wire

// ### tb/pin_function_mux_bench.sv
// self-checking bench for the pin function multiplexer
`timescale 1ns/100ps
`default_nettype none
module pin_function_mux_bench
   import pfm_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic mux_wr_en = 1'b0;
   logic main_supply_good = 1'b1;
   logic [MUX_IDX_W-1:0] mux_wr_idx = 2'h0, mux_rd_idx = 2'h0;
   logic [MUX_REG_W-1:0] mux_wr_data = 8'h00, controller_interrupt_1_mask = 8'h00;
   logic [GEN_IN_N-1:0] wake_mask = 8'h00, gen_in_pin = 8'h00;
   logic [GEN_OUT_N-1:0] gen_out_dflt = 12'h000;
   logic [GP_N-1:0] gp_dflt_out = 22'h000000, gp_dflt_oe = 22'h000000;
   logic [GP_N-1:0] gp_pin_in = 22'h000000;
   logic [3:0] key_scan_dflt = 4'hE;
   logic isa_int6 = 1'b0, isa_int8_low = 1'b0, isa_int7 = 1'b0, isa_int12 = 1'b0;
   logic isa_controller_interrupt_1 = 1'b0, sys_mgmt_interrupt_low = 1'b0, isa_int3 = 1'b0;
   logic serialized_interrupt = 1'b1, serialized_interrupt_oe = 1'b0;
   logic floppy_drive_select_1_low = 1'b0, floppy_motor_1_low = 1'b0;
   logic floppy_open_drain = 1'b0, dma_req_2 = 1'b0, cpu_reset = 1'b0;
   logic dma_req_3 = 1'b0, pulse_mod_out_0 = 1'b0, pulse_mod_out_1 = 1'b0;
   logic infrared_mode_select = 1'b0, infrared_serial_transmit = 1'b0;
   logic uart2_request_to_send_low = 1'b0, uart2_terminal_ready_low = 1'b0;
   logic addr_line_20_gate = 1'b0, controller_serial_transmit = 1'b0;
   logic kbd_port_clock_drive_low = 1'b0, kbd_port_data_drive_low = 1'b0;
   logic [MUX_REG_W-1:0] mux_rd_data;
   logic [GEN_OUT_N-1:0] gen_out_pin, gen_out_oe;
   logic [GP_N-1:0] gp_pin_out, gp_pin_oe, gp_in_value;
   logic [GEN_IN_N-1:0] gen_in_value, wake_event;
   logic [1:0] kscan_pin_out, kscan_pin_oe;
   logic [2:0] gp_wake;
   logic serialized_interrupt_pin_out, serialized_interrupt_pin_oe, controller_interrupt_1, infrared_serial_receive;
   logic fast_infrared_receive, uart2_clear_to_send_low, uart2_set_ready_low;
   logic uart2_carrier_detect_low, uart2_ring_indicator_low, media_id_bit_1;
   logic dma_ack_2_low, dma_ack_3_low, kbd_port_clock, kbd_port_data;
   logic controller_serial_receive;
   logic [5:0] v;
   int fails = 0;
   int n_tests = 0;

   pfm_pin_mux uut (.*);

   always #5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: check %0d got %h want %h", $time, n_tests, got, exp);
      end
   endtask

   // pins follow a new mux setting two edges after the write; five leaves margin
   task automatic st;
      repeat (5) @(negedge clk);
   endtask

   task automatic wr(input logic [1:0] idx, input logic [7:0] d);
      mux_wr_en = 1'b1;
      mux_wr_idx = idx;
      mux_wr_data = d;
      @(negedge clk);
      mux_wr_en = 1'b0;
      repeat (4) @(negedge clk);
   endtask

   task automatic rd(input logic [1:0] idx, input logic [7:0] exp);
      mux_rd_idx = idx;
      repeat (2) @(negedge clk);
      chk(mux_rd_data, exp);
   endtask

   task automatic clr;
      wr(2'h0, 8'h00);
      wr(2'h1, 8'h00);
      wr(2'h2, 8'h00);
   endtask

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // a hang ends in the same closing report
   initial begin
      #500000;
      fails++;
      give_verdict();
   end

   initial begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      gen_out_dflt = 12'hA5C;
      gp_dflt_out = 22'h2AAAAA;
      gp_dflt_oe = 22'h3FFFF0;
      st();
      chk(gen_out_pin, 12'hA5C);
      chk(gp_pin_out[21:4], 18'h2AAAA);
      chk(gp_pin_oe, 22'h3FFFF0);
      chk(kscan_pin_oe, 2'h1);
      chk({serialized_interrupt_pin_oe, serialized_interrupt_pin_out}, 2'h1);
      for (int i = 0; i < 3; i++) rd(2'(i), 8'h00);
      done("defaults");
      mux_rd_idx = 2'h1;
      wr(2'h0, 8'h5A);
      wr(2'h1, 8'h3C);
      wr(2'h2, 8'h03);
      wr(2'h3, 8'hFF);
      rd(2'h0, 8'h5A);
      rd(2'h1, 8'h3C);
      rd(2'h2, 8'h03);
      rd(2'h3, 8'h00);
      clr();
      done("registers");
      wr(2'h0, 8'h01);
      for (int i = 0; i < 2; i++) begin
         v = i ? 6'h2A : 6'h15;
         {sys_mgmt_interrupt_low, isa_controller_interrupt_1, isa_int12, isa_int7, isa_int8_low, isa_int6} = v;
         st();
         chk({gen_out_pin[7], gen_out_pin[4:0]}, v);
      end
      chk({serialized_interrupt_pin_oe, serialized_interrupt_pin_out}, 2'h2);
      chk(gen_out_oe[4:0], 5'h1F);
      clr();
      done("interrupt lines");
      wr(2'h0, 8'h30);
      wr(2'h1, 8'h08);
      {floppy_motor_1_low, pulse_mod_out_0, dma_req_3} = 3'h7;
      gp_pin_in = 22'h33FFFF;
      st();
      chk({gen_out_pin[11:9], gen_out_pin[6:5]}, 5'h0E);
      chk(dma_ack_3_low, 1'b0);
      chk(gen_out_oe[6:5], 2'h3);
      floppy_open_drain = 1'b1;
      st();
      chk({gen_out_oe[6:5], gen_out_pin[5]}, 3'h2);
      clr();
      done("floppy pwm dma3");
      dma_req_2 = 1'b1;
      wr(2'h1, 8'h04);
      chk(gen_out_pin[8], 1'b1);
      wr(2'h0, 8'h40);
      chk(gen_out_pin[8], 1'b0);
      chk({gp_pin_oe[17], gp_pin_out[17]}, 2'h2);
      cpu_reset = 1'b1;
      wr(2'h2, 8'h02);
      chk({kscan_pin_oe, kscan_pin_out}, 4'h8);
      chk({dma_ack_2_low, gen_out_pin[8]}, 2'h1);
      clr();
      done("dma and key scan");
      key_scan_dflt = 4'h6;
      uart2_terminal_ready_low = 1'b1;
      gp_pin_in = 22'h01A000;
      wr(2'h0, 8'h80);
      wr(2'h1, 8'h13);
      chk({gp_pin_oe[5:4], gp_pin_out[5:4]}, 4'h8);
      chk(gp_pin_oe[15:8], 8'h16);
      chk({gp_pin_out[12], gp_pin_out[9]}, 2'h2);
      v = {2'h0, uart2_ring_indicator_low, uart2_carrier_detect_low,
         uart2_set_ready_low, uart2_clear_to_send_low};
      chk(v, 6'h0A);
      chk({infrared_serial_receive, media_id_bit_1}, 2'h1);
      clr();
      done("serial lines");
      infrared_mode_select = 1'b1;
      uart2_request_to_send_low = 1'b1;
      wr(2'h0, 8'h80);
      wr(2'h1, 8'hB0);
      chk({gp_pin_out[10], gp_pin_out[6]}, 2'h3);
      main_supply_good = 1'b0;
      st();
      chk({gp_pin_oe[12], gp_pin_oe[10:9], gp_pin_oe[7:6]}, 5'h02);
      main_supply_good = 1'b1;
      st();
      chk({gp_pin_oe[12], gp_pin_oe[10:9], gp_pin_oe[7:6]}, 5'h1F);
      gp_pin_in = 22'h000040;
      wr(2'h1, 8'h40);
      chk({fast_infrared_receive, gp_pin_oe[6]}, 2'h2);
      wr(2'h2, 8'h01);
      wr(2'h1, 8'h00);
      chk({gp_pin_oe[10], gp_pin_out[10]}, 2'h3);
      gp_pin_in = 22'h000400;
      wr(2'h1, 8'h80);
      chk({fast_infrared_receive, gp_pin_oe[10]}, 2'h2);
      clr();
      done("infrared");
      kbd_port_clock_drive_low = 1'b1;
      gp_pin_in = 22'h20000F;
      gen_in_pin = 8'hFF;
      wake_mask = 8'h0E;
      controller_interrupt_1_mask = 8'h08;
      wr(2'h0, 8'h02);
      chk({kbd_port_data, kbd_port_clock}, 2'h2);
      chk({gp_pin_oe[21:20], gp_pin_out[20]}, 3'h2);
      chk({gen_in_value, wake_event}, 16'hFF0E);
      chk(gp_in_value, 22'h20000F);
      chk({gp_wake, controller_interrupt_1}, 4'hF);
      controller_interrupt_1_mask = 8'hF7;
      gp_pin_in = 22'h10000F;
      wr(2'h0, 8'h0A);
      chk({controller_serial_receive, gp_pin_oe[21], controller_interrupt_1}, 3'h6);
      done("keyboard port and wake");
      give_verdict();
   end
endmodule // pin_function_mux_bench
`default_nettype wire
